// File: common/serdes_tap_pkg.sv
// Purpose: Shared constants for the lane post-tap and link PLL control bank.
// Assumes: Eight-bit registers on a 16-bit configuration address.
// Notes:   Offsets are byte addresses on the configuration port.
package serdes_tap_pkg;
  localparam int          ADDR_W            = 16;
  localparam int          DATA_W            = 8;
  localparam int          NUM_LANES         = 4;
  localparam logic [15:0] LANE4_TAP_ADDR    = 16'h05c8;
  localparam logic [15:0] LANE5_TAP_ADDR    = 16'h05c9;
  localparam logic [15:0] LANE6_TAP_ADDR    = 16'h05ca;
  localparam logic [15:0] LANE7_TAP_ADDR    = 16'h05cb;
  localparam logic [15:0] PLL_CAL_ADDR      = 16'h1222;
  localparam logic [15:0] PLL_STARTUP_ADDR  = 16'h1228;
  localparam logic [15:0] PLL_LOCK_ADDR     = 16'h1262;
  localparam int          TAP_EN_BIT        = 7;
  localparam int          TAP_LVL_HI        = 6;
  localparam int          TAP_LVL_LO        = 4;
  localparam logic [7:0]  TAP_RESET         = 8'h00;
  localparam logic [7:0]  PLL_CAL_NORMAL    = 8'h00;
  localparam logic [7:0]  PLL_CAL_RESET     = 8'h04;
  localparam logic [7:0]  PLL_STARTUP_NORMAL = 8'h0f;
  localparam logic [7:0]  PLL_STARTUP_RESET = 8'h4f;
  localparam logic [7:0]  PLL_LOCK_NORMAL   = 8'h00;
  localparam logic [7:0]  PLL_LOCK_CLEAR    = 8'h80;
  localparam logic [2:0]  TAP_LVL_MAX       = 3'h4;
  localparam logic [7:0]  UNMAPPED_READ     = 8'h00;
endpackage

// File: verilog/lane_tap_store.sv
// Purpose: Holds the four lane post-tap control bytes.
// Assumes: One write port and one registered read port on mclk.
// Notes:   Read data come from a register one cycle after the address.
`timescale 1ns/100ps
`default_nettype none
module lane_tap_store #(
  parameter int DEPTH = 4
) (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic                     ce,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [7:0]               wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [7:0]               rd_data,
  output logic      [DEPTH*8-1:0]       all_data
);
  logic [7:0] mem_r [DEPTH];

  // The index ports need at least one bit, so a single entry is refused at elaboration.
  if (DEPTH < 2) begin : g_bad_depth
    $error("lane_tap_store needs at least two entries.");
  end

  // Each entry resets to zero so every post tap starts disabled at 0 dB.
  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_ent
    always_ff @(posedge mclk) begin
      if (srst) begin
        mem_r[g] <= serdes_tap_pkg::TAP_RESET;
      end else if (ce && wr_en && wr_idx == g) begin
        mem_r[g] <= wr_data;
      end
    end
    assign all_data[g*8 +: 8] = mem_r[g];
  end

  // Registered read keeps the read path out of the decode timing.
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_data <= serdes_tap_pkg::TAP_RESET;
    end else if (ce) begin
      rd_data <= mem_r[rd_idx];
    end
  end
endmodule
`default_nettype wire

// File: verilog/serdes_tap_and_pll_ctrl_regs.sv
// Purpose: Lane 4-7 post-tap control and link PLL control register bank.
// Assumes: A simple same-clock configuration port: addr, wr, rd, wdata.
// Notes:   Read data are valid on cfg_rdata one cycle after cfg_rd.
`timescale 1ns/100ps
`default_nettype none
module serdes_tap_and_pll_ctrl_regs (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic [15:0] cfg_addr,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_wdata,
  output logic      [7:0]  cfg_rdata,
  output logic             cfg_rvalid,
  input  wire logic        pll_lock_lost,
  output logic      [3:0]  post_tap_en,
  output logic      [11:0] post_tap_level,
  output logic             pll_cal_rst,
  output logic             pll_startup_rst,
  output logic             lock_loss_flag
);
  logic [7:0]  cal_r;
  logic [7:0]  cal_nxt;
  logic [7:0]  startup_r;
  logic [7:0]  startup_nxt;
  logic [7:0]  lock_ctl_r;
  logic [7:0]  lock_ctl_nxt;
  logic        flag_r;
  logic        flag_nxt;
  logic        lost_s1_r;
  logic        lost_s2_r;
  logic [7:0]  misc_rd_r;
  logic        rd_lane_r;
  logic        rvalid_r;
  logic [7:0]  lane_rd;
  logic [31:0] lane_all;

  // Address decode shared by the read and write paths.
  function automatic logic is_lane(input logic [15:0] a);
    return a >= serdes_tap_pkg::LANE4_TAP_ADDR && a <= serdes_tap_pkg::LANE7_TAP_ADDR;
  endfunction

  wire        wr_lane   = cfg_wr && is_lane(cfg_addr);
  wire        wr_cal    = cfg_wr && cfg_addr == serdes_tap_pkg::PLL_CAL_ADDR;
  wire        wr_start  = cfg_wr && cfg_addr == serdes_tap_pkg::PLL_STARTUP_ADDR;
  wire        wr_lock   = cfg_wr && cfg_addr == serdes_tap_pkg::PLL_LOCK_ADDR;
  wire [1:0]  lane_idx  = cfg_addr[1:0];

  lane_tap_store #(
    .DEPTH(serdes_tap_pkg::NUM_LANES)
  ) u_store (
    .mclk    (mclk),
    .srst    (srst),
    .ce      (ce),
    .wr_en   (wr_lane),
    .wr_idx  (lane_idx),
    .wr_data (cfg_wdata),
    .rd_idx  (lane_idx),
    .rd_data (lane_rd),
    .all_data(lane_all)
  );

  // Per-lane field extraction onto the analog driver controls.
  genvar l;
  for (l = 0; l < serdes_tap_pkg::NUM_LANES; l++) begin : g_lane
    assign post_tap_en[l] = lane_all[l*8 + serdes_tap_pkg::TAP_EN_BIT];
    assign post_tap_level[l*3 +: 3] =
      lane_all[l*8 + serdes_tap_pkg::TAP_LVL_LO +: 3];
  end

  // Next values for the PLL control bytes; they store whatever is written.
  assign cal_nxt      = wr_cal ? cfg_wdata : cal_r;
  assign startup_nxt  = wr_start ? cfg_wdata : startup_r;
  assign lock_ctl_nxt = wr_lock ? cfg_wdata : lock_ctl_r;

  // PLL reset controls are levels decoded from the stored byte.
  assign pll_cal_rst     = cal_r == serdes_tap_pkg::PLL_CAL_RESET;
  assign pll_startup_rst = startup_r == serdes_tap_pkg::PLL_STARTUP_RESET;
  wire   lock_clear      = lock_ctl_r == serdes_tap_pkg::PLL_LOCK_CLEAR;

  // A new loss of lock wins over a clear in the same cycle so no event is lost.
  assign flag_nxt = lost_s2_r ? 1'b1 : (lock_clear ? 1'b0 : flag_r);
  assign lock_loss_flag = flag_r;

  // The lock-loss input comes from the PLL domain and is synchronised first.
  always_ff @(posedge mclk) begin
    if (srst) begin
      lost_s1_r <= 1'b0;
      lost_s2_r <= 1'b0;
    end else if (ce) begin
      lost_s1_r <= pll_lock_lost;
      lost_s2_r <= lost_s1_r;
    end
  end

  // Control byte storage with documented reset values.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cal_r      <= serdes_tap_pkg::PLL_CAL_NORMAL;
      startup_r  <= serdes_tap_pkg::PLL_STARTUP_NORMAL;
      lock_ctl_r <= serdes_tap_pkg::PLL_LOCK_NORMAL;
      flag_r     <= 1'b0;
    end else if (ce) begin
      cal_r      <= cal_nxt;
      startup_r  <= startup_nxt;
      lock_ctl_r <= lock_ctl_nxt;
      flag_r     <= flag_nxt;
    end
  end

  // Read mux for the non-lane registers; unmapped addresses read zero.
  wire [7:0] misc_sel =
    cfg_addr == serdes_tap_pkg::PLL_CAL_ADDR     ? cal_r :
    cfg_addr == serdes_tap_pkg::PLL_STARTUP_ADDR ? startup_r :
    cfg_addr == serdes_tap_pkg::PLL_LOCK_ADDR    ? lock_ctl_r :
    serdes_tap_pkg::UNMAPPED_READ;

  always_ff @(posedge mclk) begin
    if (srst) begin
      misc_rd_r <= serdes_tap_pkg::UNMAPPED_READ;
      rd_lane_r <= 1'b0;
      rvalid_r  <= 1'b0;
    end else if (ce) begin
      misc_rd_r <= misc_sel;
      rd_lane_r <= is_lane(cfg_addr);
      rvalid_r  <= cfg_rd;
    end
  end

  assign cfg_rdata  = rd_lane_r ? lane_rd : misc_rd_r;
  assign cfg_rvalid = rvalid_r;

  // Field views of the write data, read only by the properties below.
  wire       wdata_en  = cfg_wdata[serdes_tap_pkg::TAP_EN_BIT];
  wire [2:0] wdata_lvl = cfg_wdata[serdes_tap_pkg::TAP_LVL_HI:serdes_tap_pkg::TAP_LVL_LO];

  // Properties judge the PLL reset and tap outputs against the written codes, not against the internal decode,
  // so a broken address or value decode shows up here rather than passing silently.
  chk_cal_reset_level: assert property (@(posedge mclk) disable iff (srst)
    (ce && cfg_wr && cfg_addr == serdes_tap_pkg::PLL_CAL_ADDR &&
     cfg_wdata == serdes_tap_pkg::PLL_CAL_RESET) |=> pll_cal_rst)
    else $error("Calibration reset not asserted.");
  chk_cal_normal: assert property (@(posedge mclk) disable iff (srst)
    (ce && cfg_wr && cfg_addr == serdes_tap_pkg::PLL_CAL_ADDR &&
     cfg_wdata == serdes_tap_pkg::PLL_CAL_NORMAL) |=> !pll_cal_rst)
    else $error("Calibration reset in normal.");
  chk_startup_reset: assert property (@(posedge mclk) disable iff (srst)
    (ce && cfg_wr && cfg_addr == serdes_tap_pkg::PLL_STARTUP_ADDR &&
     cfg_wdata == serdes_tap_pkg::PLL_STARTUP_RESET) |=> pll_startup_rst)
    else $error("Startup reset not asserted.");
  chk_startup_normal: assert property (@(posedge mclk)
    $fell(srst) |-> startup_r == serdes_tap_pkg::PLL_STARTUP_NORMAL && !pll_startup_rst)
    else $error("Startup not normal after reset.");
  chk_startup_restore: assert property (@(posedge mclk) disable iff (srst)
    (ce && cfg_wr && cfg_addr == serdes_tap_pkg::PLL_STARTUP_ADDR &&
     cfg_wdata == serdes_tap_pkg::PLL_STARTUP_NORMAL) |=> !pll_startup_rst)
    else $error("Startup reset held after normal code.");
  chk_flag_clear: assert property (@(posedge mclk) disable iff (srst)
    (ce && lock_ctl_r == serdes_tap_pkg::PLL_LOCK_CLEAR && !lost_s2_r) |=> !lock_loss_flag)
    else $error("Lock loss flag not cleared.");
  chk_flag_set_wins: assert property (@(posedge mclk) disable iff (srst)
    (ce && lost_s2_r) |=> lock_loss_flag)
    else $error("Lock loss event lost.");
  chk_flag_hold: assert property (@(posedge mclk) disable iff (srst)
    (ce && lock_ctl_r == serdes_tap_pkg::PLL_LOCK_NORMAL && lock_loss_flag) |=> lock_loss_flag)
    else $error("Lock loss flag dropped in normal.");
  chk_lane4_fields: assert property (@(posedge mclk) disable iff (srst)
    (ce && cfg_wr && cfg_addr == serdes_tap_pkg::LANE4_TAP_ADDR) |=>
    post_tap_en[0] == $past(wdata_en) && post_tap_level[2:0] == $past(wdata_lvl))
    else $error("Lane 4 fields wrong.");
  chk_lane5_fields: assert property (@(posedge mclk) disable iff (srst)
    (ce && cfg_wr && cfg_addr == serdes_tap_pkg::LANE5_TAP_ADDR) |=>
    post_tap_en[1] == $past(wdata_en) && post_tap_level[5:3] == $past(wdata_lvl))
    else $error("Lane 5 fields wrong.");
  chk_lane6_fields: assert property (@(posedge mclk) disable iff (srst)
    (ce && cfg_wr && cfg_addr == serdes_tap_pkg::LANE6_TAP_ADDR) |=>
    post_tap_en[2] == $past(wdata_en) && post_tap_level[8:6] == $past(wdata_lvl))
    else $error("Lane 6 fields wrong.");
  chk_lane6_reset: assert property (@(posedge mclk)
    $fell(srst) |-> !post_tap_en[2] && post_tap_level[8:6] == 3'h0)
    else $error("Lane 6 not zero after reset.");
  chk_lane7_fields: assert property (@(posedge mclk) disable iff (srst)
    (ce && cfg_wr && cfg_addr == serdes_tap_pkg::LANE7_TAP_ADDR) |=>
    post_tap_en[3] == $past(wdata_en) && post_tap_level[11:9] == $past(wdata_lvl))
    else $error("Lane 7 fields wrong.");
  chk_lane7_readback: assert property (@(posedge mclk) disable iff (srst)
    (ce && cfg_wr && cfg_addr == serdes_tap_pkg::LANE7_TAP_ADDR) ##1
    (ce && cfg_rd && !cfg_wr && cfg_addr == serdes_tap_pkg::LANE7_TAP_ADDR)
    |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("Lane 7 readback wrong.");
  chk_read_valid: assert property (@(posedge mclk) disable iff (srst)
    ce |=> cfg_rvalid == $past(cfg_rd))
    else $error("Read valid not one cycle after read.");
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Purpose: Self-checking bench for the lane post-tap and link PLL control bank.
// Assumes: One-cycle strobes on the configuration port, inputs moved 1 ns after mclk rises.
// Notes:   Each scenario task drives the bank and judges the answer before it returns.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        mclk, srst, ce, cfg_wr, cfg_rd, pll_lock_lost;
  logic [15:0] cfg_addr;
  logic [7:0]  cfg_wdata, cfg_rdata;
  logic        cfg_rvalid, pll_cal_rst, pll_startup_rst, lock_loss_flag;
  logic [3:0]  post_tap_en;
  logic [11:0] post_tap_level;
  int          fail_count, total_checks;

  serdes_tap_and_pll_ctrl_regs dut (.mclk(mclk), .srst(srst), .ce(ce), .cfg_addr(cfg_addr),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .pll_lock_lost(pll_lock_lost), .post_tap_en(post_tap_en),
    .post_tap_level(post_tap_level), .pll_cal_rst(pll_cal_rst),
    .pll_startup_rst(pll_startup_rst), .lock_loss_flag(lock_loss_flag));

  // A 100 ns clock; every input moves 1 ns after the rising edge to stay clear of sampling.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("Checks made: %0d, mismatches: %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One write; returns 1 ns after the edge that took it, when its effect is visible.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk); #1;
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(posedge mclk); #1;
    cfg_wr = 1'b0;
  endtask

  // One read; the answer must stand with its valid pulse right after the taking edge.
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk); #1;
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(posedge mclk); #1;
    cfg_rd = 1'b0;
    chk("read valid", 16'h0001, {15'h0000, cfg_rvalid});
    chk("read data", {8'h00, exp}, {8'h00, cfg_rdata});
    @(posedge mclk); #1;
    chk("read valid end", 16'h0000, {15'h0000, cfg_rvalid});
  endtask

  // Every register and output must show its reset value straight after reset.
  task automatic reset_values();
    rd(serdes_tap_pkg::LANE4_TAP_ADDR, 8'h00);
    rd(serdes_tap_pkg::LANE5_TAP_ADDR, 8'h00);
    rd(serdes_tap_pkg::LANE6_TAP_ADDR, 8'h00);
    rd(serdes_tap_pkg::LANE7_TAP_ADDR, 8'h00);
    rd(serdes_tap_pkg::PLL_CAL_ADDR, 8'h00);
    rd(serdes_tap_pkg::PLL_STARTUP_ADDR, 8'h0f);
    rd(serdes_tap_pkg::PLL_LOCK_ADDR, 8'h00);
    chk("tap enables", 16'h0000, {12'h000, post_tap_en});
    chk("tap levels", 16'h0000, {4'h0, post_tap_level});
    chk("pll resets", 16'h0000, {14'h0000, pll_cal_rst, pll_startup_rst});
    chk("lock flag", 16'h0000, {15'h0000, lock_loss_flag});
  endtask

  // Each lane takes every defined level code, with the enable toggling and reserved bits kept.
  task automatic lane_codes();
    logic [7:0] d;
    for (int ln = 0; ln < 4; ln++) begin
      for (int c = 0; c <= 4; c++) begin
        d = {c[0], c[2:0], 4'ha ^ ln[3:0]};
        wr(serdes_tap_pkg::LANE4_TAP_ADDR + 16'(ln), d);
        chk("lane enable", {15'h0000, c[0]}, {15'h0000, post_tap_en[ln]});
        chk("lane level", {13'h0000, c[2:0]}, {13'h0000, post_tap_level[3*ln+:3]});
        rd(serdes_tap_pkg::LANE4_TAP_ADDR + 16'(ln), d);
      end
    end
    // Distinct final bytes show that no lane writes into a neighbour.
    wr(serdes_tap_pkg::LANE5_TAP_ADDR, 8'hb0);
    wr(serdes_tap_pkg::LANE7_TAP_ADDR, 8'h90);
    chk("all enables", 16'h000a, {12'h000, post_tap_en});
    chk("all levels", 16'h031c, {4'h0, post_tap_level});
  endtask

  // Reset codes hold their PLL function in reset only while stored; any other code written releases it.
  task automatic pll_controls();
    wr(serdes_tap_pkg::PLL_CAL_ADDR, 8'h04);
    chk("cal reset on", 16'h0001, {15'h0000, pll_cal_rst});
    wr(serdes_tap_pkg::PLL_CAL_ADDR, 8'h05);
    chk("cal other code", 16'h0000, {15'h0000, pll_cal_rst});
    wr(serdes_tap_pkg::PLL_CAL_ADDR, 8'h00);
    chk("cal normal", 16'h0000, {15'h0000, pll_cal_rst});
    wr(serdes_tap_pkg::PLL_STARTUP_ADDR, 8'h4f);
    chk("startup reset on", 16'h0001, {15'h0000, pll_startup_rst});
    rd(serdes_tap_pkg::PLL_STARTUP_ADDR, 8'h4f);
    wr(serdes_tap_pkg::PLL_STARTUP_ADDR, 8'h0f);
    chk("startup normal", 16'h0000, {15'h0000, pll_startup_rst});
  endtask

  // A lock loss sets the sticky flag three cycles on; the clear code drops it one cycle later.
  task automatic lock_loss();
    int n;
    @(posedge mclk); #1;
    pll_lock_lost = 1'b1;
    n = 0;
    while (lock_loss_flag !== 1'b1 && n < 8) begin
      @(posedge mclk); #1;
      pll_lock_lost = 1'b0;
      n++;
    end
    if (n == 8) begin
      chk("lock loss wait", 16'h0001, 16'h0000);
      test_done();
    end
    chk("flag latency", 16'h0003, 16'(n));
    repeat (4) @(posedge mclk);
    #1 chk("flag sticky", 16'h0001, {15'h0000, lock_loss_flag});
    wr(serdes_tap_pkg::PLL_LOCK_ADDR, 8'h80);
    @(posedge mclk); #1;
    chk("flag cleared", 16'h0000, {15'h0000, lock_loss_flag});
    // With the clear code still stored, a new loss must still show for one cycle.
    @(posedge mclk); #1;
    pll_lock_lost = 1'b1;
    @(posedge mclk); #1;
    pll_lock_lost = 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("set beats clear", 16'h0001, {15'h0000, lock_loss_flag});
    wr(serdes_tap_pkg::PLL_LOCK_ADDR, 8'h00);
    rd(serdes_tap_pkg::PLL_LOCK_ADDR, 8'h00);
  endtask

  // Unmapped places read as zero and ignore writes; a held clock enable ignores everything.
  task automatic refusals();
    wr(16'h05cc, 8'hff);
    rd(16'h05cc, serdes_tap_pkg::UNMAPPED_READ);
    @(posedge mclk); #1;
    ce = 1'b0;
    wr(serdes_tap_pkg::LANE4_TAP_ADDR, 8'hc5);
    chk("frozen enable", 16'h0000, {15'h0000, post_tap_en[0]});
    @(posedge mclk); #1;
    ce = 1'b1;
    rd(serdes_tap_pkg::LANE4_TAP_ADDR, 8'h4a);
  endtask

  // A write followed at once by a read of the same lane must return the new byte.
  task automatic back_to_back();
    @(posedge mclk); #1;
    cfg_addr = serdes_tap_pkg::LANE7_TAP_ADDR;
    cfg_wdata = 8'hb3;
    cfg_wr = 1'b1;
    @(posedge mclk); #1;
    cfg_wr = 1'b0;
    cfg_rd = 1'b1;
    @(posedge mclk); #1;
    cfg_rd = 1'b0;
    chk("back to back valid", 16'h0001, {15'h0000, cfg_rvalid});
    chk("back to back data", 16'h00b3, {8'h00, cfg_rdata});
  endtask

  // A reset in mid-run must override stored reset codes and return every register to its value.
  task automatic mid_reset();
    wr(serdes_tap_pkg::PLL_CAL_ADDR, serdes_tap_pkg::PLL_CAL_RESET);
    wr(serdes_tap_pkg::PLL_STARTUP_ADDR, serdes_tap_pkg::PLL_STARTUP_RESET);
    @(posedge mclk); #1;
    srst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 srst = 1'b0;
    reset_values();
  endtask

  // Main sequence: sixteen cycles of reset, then each scenario in turn.
  initial begin
    fail_count = 0;
    total_checks = 0;
    srst = 1'b1;
    ce = 1'b1;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    pll_lock_lost = 1'b0;
    cfg_addr = 16'h0000;
    cfg_wdata = 8'h00;
    repeat (16) @(posedge mclk);
    #1 srst = 1'b0;
    reset_values();
    lane_codes();
    back_to_back();
    pll_controls();
    lock_loss();
    refusals();
    mid_reset();
    test_done();
  end
endmodule
`default_nettype wire
